// *** relay_selector_pkg.sv ***
// Purpose: shared constants and types for the system channel relay selector
// Assumes: one 20 MHz clock, AXI4-Lite register access, twenty-channel modules
// Notes:   offsets are byte addresses of 32-bit words

package relay_selector_pkg;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned ID_SHOW_MS  = 500;                          // identity shown per slot
  localparam int unsigned ID_SHOW_CYC = ID_SHOW_MS * (CLK_HZ / 1000);
  localparam logic [1:0]  SETTLE_CYC  = 2'h2;                         // synchroniser fill time

  // ---------------------------------------------------------------------------
  // slots and relays
  // ---------------------------------------------------------------------------
  localparam int unsigned NUM_SLOTS     = 5;
  localparam int unsigned NUM_RELAYS    = 25;
  localparam logic [6:0]  MAX_CH_2W     = 7'h14;  // channels 1..20 measure
  localparam logic [6:0]  MAX_CH_4W     = 7'h0A;  // channels 1..10 in four-wire
  localparam logic [4:0]  PAIR_OFS      = 5'h0A;  // channel n pairs with n+10
  localparam logic [4:0]  IDX_POLE      = 5'h16;  // relay 23
  localparam logic [4:0]  IDX_SENSE_ISO = 5'h17;  // relay 24
  localparam logic [4:0]  IDX_INPUT_ISO = 5'h18;  // relay 25
  localparam logic [3:0]  MAX_DIGIT     = 4'h9;

  // ---------------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL  = 8'h00;
  localparam logic [7:0]  ADDR_CMD   = 8'h04;
  localparam logic [7:0]  ADDR_SYS   = 8'h08;
  localparam logic [7:0]  ADDR_STAT  = 8'h0C;
  localparam logic [7:0]  ADDR_MASK  = 8'h10;
  localparam logic [7:0]  ADDR_SLOTS = 8'h14;
  localparam int unsigned CTRL_FOUR_WIRE = 0;
  localparam int unsigned STAT_DONE      = 0;
  localparam int unsigned STAT_ERR       = 1;
  localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
  localparam logic [1:0]  MASK_RST       = 2'h0;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef enum logic [1:0] {OP_NONE, OP_CLOSE, OP_OPEN_ALL, OP_ASSIGN} op_t;

  // command word written to ADDR_CMD
  typedef struct packed {
    logic [15:0] rsvd;
    logic        from_panel;         // 1: came from front-panel keys
    logic        virt_meas;          // virtual module has measurement channels
    op_t         op;
    logic [11:0] slot_channel_code;  // slot digit, channel tens, channel ones
  } cmd_t;

  typedef struct packed {
    logic        valid;
    logic [11:0] code;
  } sys_chan_t;

endpackage

// *** system_channel_relay_selector.sv ***
// Purpose: system channel selection and relay drive across five module slots
// Assumes: slot_present/slot_meas are pins; every module has twenty channels
// Notes:   one command at a time; break-before-make on every close
// Behaviour
// - channel code is slot digit then two channel digits
// - five slots, each real module or virtual stand-in
// - at most one system channel; none when nothing displayed
// - closing system channel also closes input isolation relay 25
// - four-wire close also closes pair and sense isolation relay 24
// - new close opens previous; new channel becomes system channel
// - close of non-measurement or unconnectable channel refused, nothing closes
// - four-wire: only channels 1-10 selectable, n pairs with n+10
// - four-wire also closes pole-mode relay 23
// - system channel to meter input, pair to sense input
// - system channel number displayed, pair number not
// - virtual assignment only to empty slot, else refused
// - virtual assignments volatile, cleared at power-up reset
// - slot lamp on while virtual module assigned
// - virtual assignment only from remote, never front panel
// - installed module identities shown briefly at power-up
// - previous channel and pair opened before new close
// - open-all opens every relay, leaves no system channel
`timescale 1ns/1ps

module system_channel_relay_selector
  import relay_selector_pkg::*;
#(
  parameter int unsigned ID_SHOW_CYCLES = ID_SHOW_CYC
) (
  input  wire logic         clock,
  input  wire logic         srst,
  input  wire logic [7:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [7:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  input  wire logic [4:0]   slot_present,
  input  wire logic [4:0]   slot_meas,
  output logic [124:0]      relay_drive,
  output logic [4:0]        slot_lamp,
  output logic              disp_chan_valid,
  output logic [11:0]       disp_chan_code,
  output logic              disp_ident_valid,
  output logic [2:0]        disp_ident_slot,
  output logic              disp_ident_meas,
  output logic              irq
);

  typedef enum {ST_SETTLE, ST_BOOT, ST_IDLE, ST_BREAK, ST_MAKE} state_t;

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic digits_ok(input logic [11:0] c);
    return (c[11:8] <= MAX_DIGIT) && (c[7:4] <= MAX_DIGIT) && (c[3:0] <= MAX_DIGIT);
  endfunction

  function automatic logic [6:0] chan_num(input logic [7:0] d);
    return ({3'h0, d[7:4]} * 7'h0A) + {3'h0, d[3:0]};
  endfunction

  function automatic logic slot_ok(input logic [3:0] s);
    return (s >= 4'h1) && (s <= 4'h5);
  endfunction

  // ---------------------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------------------
  state_t            state_q;
  logic [4:0][24:0]  relay_q;
  sys_chan_t         sys_q;
  logic [4:0]        virt_q;
  logic [4:0]        vmeas_q;
  logic [31:0]       ctrl_q;
  logic [1:0]        stat_q;
  logic [1:0]        mask_q;
  logic [4:0]        pres_s1_q;
  logic [4:0]        pres_q;
  logic [4:0]        meas_s1_q;
  logic [4:0]        meas_q;
  logic [23:0]       boot_cnt_q;
  logic [2:0]        boot_slot_q;
  logic [2:0]        pend_slot_q;
  logic [4:0]        pend_ch_q;
  logic              pend_4w_q;
  logic [11:0]       pend_code_q;
  logic              aw_have_q;
  logic              w_have_q;
  logic [7:0]        aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              bvalid_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;
  logic [31:0]       wmask;
  logic              wr_fire;
  logic              cmd_go;
  cmd_t              cmd;
  logic [2:0]        cmd_slot;
  logic [6:0]        cmd_ch;
  logic [4:0]        occupied;
  logic [4:0]        meas_cap;
  logic              close_ok;
  logic              close_bad;
  logic              open_go;
  logic              assign_ok;
  logic              assign_bad;
  logic              busy_bad;
  logic [1:0]        stat_set;
  logic [1:0]        stat_clr;
  logic [31:0]       rdata_d;
  logic              raddr_ok;

  // ---------------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------------
  // module presence pins are asynchronous to the clock
  always_ff @(posedge clock) begin
    if (srst) begin
      pres_s1_q <= 5'h00;
      pres_q    <= 5'h00;
      meas_s1_q <= 5'h00;
      meas_q    <= 5'h00;
    end else begin
      pres_s1_q <= slot_present;
      pres_q    <= pres_s1_q;
      meas_s1_q <= slot_meas;
      meas_q    <= meas_s1_q;
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite write path
  // ---------------------------------------------------------------------------
  // address and data are held independently, so they may arrive in any order
  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready  = !w_have_q;
  assign wr_fire       = aw_have_q && w_have_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = RESP_OKAY;  // writes to unmapped words are dropped

  always_ff @(posedge clock) begin
    if (srst) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // byte lanes expanded to a bit mask
  for (genvar b = 0; b < 4; b++) begin : g_wmask
    assign wmask[b*8 +: 8] = {8{w_strb_q[b]}};
  end

  // ---------------------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------------------
  assign cmd      = cmd_t'(w_data_q & wmask);
  assign cmd_go   = wr_fire && (aw_addr_q == ADDR_CMD);
  assign cmd_slot = 3'(cmd.slot_channel_code[11:8] - 4'h1);
  assign cmd_ch   = chan_num(cmd.slot_channel_code[7:0]);
  assign occupied = pres_q | virt_q;
  assign meas_cap = (pres_q & meas_q) | (virt_q & vmeas_q);

  // only channels that reach the meter qualify; 21..25 are never selectable
  always_comb begin
    close_ok = digits_ok(cmd.slot_channel_code) && slot_ok(cmd.slot_channel_code[11:8]);
    if (close_ok) begin
      close_ok = occupied[cmd_slot] && meas_cap[cmd_slot] && (cmd_ch != 7'h00) &&
                 (cmd_ch <= (ctrl_q[CTRL_FOUR_WIRE] ? MAX_CH_4W : MAX_CH_2W));
    end
  end

  // a command arriving mid-sequence is refused rather than queued
  always_comb begin
    busy_bad   = cmd_go && (state_q != ST_IDLE) && (cmd.op != OP_NONE);
    open_go    = cmd_go && (state_q == ST_IDLE) && (cmd.op == OP_OPEN_ALL);
    close_bad  = cmd_go && (state_q == ST_IDLE) && (cmd.op == OP_CLOSE) && !close_ok;
    assign_ok  = cmd_go && (state_q == ST_IDLE) && (cmd.op == OP_ASSIGN) && !cmd.from_panel &&
                 slot_ok(cmd.slot_channel_code[11:8]) && !occupied[cmd_slot];
    assign_bad = cmd_go && (state_q == ST_IDLE) && (cmd.op == OP_ASSIGN) && !assign_ok;
  end

  // ---------------------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------------------
  // boot walks the slots showing each installed module's identity
  always_ff @(posedge clock) begin
    if (srst) begin
      state_q     <= ST_SETTLE;
      boot_cnt_q  <= 24'h00_0000;
      boot_slot_q <= 3'h0;
    end else begin
      unique case (state_q)
        ST_SETTLE: begin
          boot_cnt_q <= boot_cnt_q + 24'h00_0001;
          if (boot_cnt_q[1:0] == SETTLE_CYC) begin
            state_q    <= ST_BOOT;
            boot_cnt_q <= 24'h00_0000;
          end
        end
        ST_BOOT: begin
          boot_cnt_q <= boot_cnt_q + 24'h00_0001;
          if (!pres_q[boot_slot_q] || (boot_cnt_q == 24'(ID_SHOW_CYCLES - 1))) begin
            boot_cnt_q  <= 24'h00_0000;
            boot_slot_q <= boot_slot_q + 3'h1;
            if (boot_slot_q == 3'(NUM_SLOTS - 1)) begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_IDLE: begin
          if (cmd_go && (cmd.op == OP_CLOSE) && close_ok) begin
            state_q <= ST_BREAK;
          end
        end
        ST_BREAK: state_q <= ST_MAKE;
        ST_MAKE:  state_q <= ST_IDLE;
      endcase
    end
  end

  // target latched so a later CTRL write cannot change a close in flight
  always_ff @(posedge clock) begin
    if (srst) begin
      pend_slot_q <= 3'h0;
      pend_ch_q   <= 5'h00;
      pend_4w_q   <= 1'b0;
      pend_code_q <= 12'h000;
    end else if (cmd_go && (state_q == ST_IDLE) && (cmd.op == OP_CLOSE) && close_ok) begin
      pend_slot_q <= cmd_slot;
      pend_ch_q   <= cmd_ch[4:0];
      pend_4w_q   <= ctrl_q[CTRL_FOUR_WIRE];
      pend_code_q <= cmd.slot_channel_code;
    end
  end

  // ---------------------------------------------------------------------------
  // relays and system channel
  // ---------------------------------------------------------------------------
  // only the system channel set is ever closed, so breaking clears everything
  always_ff @(posedge clock) begin
    if (srst) begin
      relay_q <= '0;
    end else if (open_go || (state_q == ST_BREAK)) begin
      relay_q <= '0;
    end else if (state_q == ST_MAKE) begin
      relay_q[pend_slot_q][5'(pend_ch_q - 5'h01)] <= 1'b1;
      relay_q[pend_slot_q][IDX_INPUT_ISO]         <= 1'b1;
      if (pend_4w_q) begin
        relay_q[pend_slot_q][5'(pend_ch_q + PAIR_OFS - 5'h01)] <= 1'b1;
        relay_q[pend_slot_q][IDX_SENSE_ISO]                    <= 1'b1;
        relay_q[pend_slot_q][IDX_POLE]                         <= 1'b1;
      end
    end
  end

  // single record means a second system channel cannot exist
  always_ff @(posedge clock) begin
    if (srst) begin
      sys_q <= '0;
    end else if (open_go || (state_q == ST_BREAK)) begin
      sys_q <= '0;
    end else if (state_q == ST_MAKE) begin
      sys_q <= '{valid: 1'b1, code: pend_code_q};
    end
  end

  assign relay_drive     = relay_q;
  assign disp_chan_valid = sys_q.valid;  // pair never reaches the display
  assign disp_chan_code  = sys_q.code;

  // ---------------------------------------------------------------------------
  // virtual modules and display of identities
  // ---------------------------------------------------------------------------
  // no retention: reset stands in for power-off
  always_ff @(posedge clock) begin
    if (srst) begin
      virt_q  <= 5'h00;
      vmeas_q <= 5'h00;
    end else if (assign_ok) begin
      virt_q[cmd_slot]  <= 1'b1;
      vmeas_q[cmd_slot] <= cmd.virt_meas;
    end
  end

  assign slot_lamp = virt_q;

  always_ff @(posedge clock) begin
    if (srst) begin
      disp_ident_valid <= 1'b0;
      disp_ident_slot  <= 3'h0;
      disp_ident_meas  <= 1'b0;
    end else begin
      disp_ident_valid <= (state_q == ST_BOOT) && pres_q[boot_slot_q];
      disp_ident_slot  <= boot_slot_q;
      disp_ident_meas  <= (state_q == ST_BOOT) && meas_q[boot_slot_q];  // slot index runs past 4 after boot
    end
  end

  // ---------------------------------------------------------------------------
  // control, status and interrupt registers
  // ---------------------------------------------------------------------------
  assign stat_set = {close_bad | assign_bad | busy_bad, (state_q == ST_MAKE) | open_go | assign_ok};
  assign stat_clr = (wr_fire && (aw_addr_q == ADDR_STAT)) ? (w_data_q[1:0] & wmask[1:0]) : 2'h0;

  // set wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_q <= CTRL_RST;
      mask_q <= MASK_RST;
      stat_q <= 2'h0;
    end else begin
      stat_q <= (stat_q & ~stat_clr) | stat_set;
      if (wr_fire && (aw_addr_q == ADDR_CTRL)) begin
        ctrl_q <= {31'h0000_0000, (w_data_q[CTRL_FOUR_WIRE] & wmask[CTRL_FOUR_WIRE]) |
                                  (ctrl_q[CTRL_FOUR_WIRE] & ~wmask[CTRL_FOUR_WIRE])};
      end
      if (wr_fire && (aw_addr_q == ADDR_MASK)) begin
        mask_q <= (w_data_q[1:0] & wmask[1:0]) | (mask_q & ~wmask[1:0]);
      end
    end
  end

  assign irq = |(stat_q & mask_q);

  // ---------------------------------------------------------------------------
  // AXI4-Lite read path
  // ---------------------------------------------------------------------------
  always_comb begin
    rdata_d  = 32'h0000_0000;
    raddr_ok = 1'b1;
    unique case (s_axi_araddr)
      ADDR_CTRL:  rdata_d = ctrl_q;
      ADDR_CMD:   rdata_d = 32'h0000_0000;
      ADDR_SYS:   rdata_d = {18'h0_0000, state_q != ST_IDLE, sys_q.valid, sys_q.code};
      ADDR_STAT:  rdata_d = {30'h0000_0000, stat_q};
      ADDR_MASK:  rdata_d = {30'h0000_0000, mask_q};
      ADDR_SLOTS: rdata_d = {17'h0_0000, meas_cap, virt_q, pres_q};
      default:    raddr_ok = 1'b0;
    endcase
  end

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge clock) begin
    if (srst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rdata_d;
      rresp_q  <= raddr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  AST_NO_SYS_ALL_OPEN: assert property (@(posedge clock) disable iff (srst)
    (state_q == ST_IDLE && !sys_q.valid) |-> (relay_q == '0))
    else $error("relay closed with no system channel");

  AST_INPUT_ISO: assert property (@(posedge clock) disable iff (srst)
    (state_q == ST_MAKE) |=> (relay_q[pend_slot_q][IDX_INPUT_ISO] && sys_q.valid))
    else $error("input isolation relay not closed with system channel");

  AST_FOUR_WIRE_SET: assert property (@(posedge clock) disable iff (srst)
    (state_q == ST_MAKE && pend_4w_q) |=> (relay_q[pend_slot_q][5'(pend_ch_q + PAIR_OFS - 5'h01)] &&
      relay_q[pend_slot_q][IDX_SENSE_ISO] && relay_q[pend_slot_q][IDX_POLE]))
    else $error("four-wire pair, sense or pole relay missing");

  AST_NEW_SYS_SHOWN: assert property (@(posedge clock) disable iff (srst)
    (state_q == ST_MAKE) |=> (disp_chan_valid && disp_chan_code == $past(pend_code_q)))
    else $error("new system channel not displayed");

  AST_REFUSE_CLOSE: assert property (@(posedge clock) disable iff (srst)
    close_bad |=> ($stable(relay_q) && stat_q[STAT_ERR] && state_q == ST_IDLE))
    else $error("refused close changed relays or raised no error");

  AST_BREAK_FIRST: assert property (@(posedge clock) disable iff (srst)
    (cmd_go && state_q == ST_IDLE && cmd.op == OP_CLOSE && close_ok) |=> ##1 (relay_q == '0 && !sys_q.valid))
    else $error("previous channel not opened before make");

  AST_OPEN_ALL: assert property (@(posedge clock) disable iff (srst)
    open_go |=> (relay_q == '0 && !disp_chan_valid))
    else $error("open-all left a relay closed");

  AST_ASSIGN_REFUSED: assert property (@(posedge clock) disable iff (srst)
    (cmd_go && cmd.op == OP_ASSIGN && (occupied[cmd_slot] || cmd.from_panel)) |=> $stable(virt_q))
    else $error("virtual module assigned to occupied slot or from panel");

  AST_LAMP_ON: assert property (@(posedge clock) disable iff (srst)
    assign_ok |=> slot_lamp[$past(cmd_slot)])
    else $error("slot lamp not lit after virtual assignment");

  AST_VIRT_VOLATILE: assert property (@(posedge clock)
    srst |=> (virt_q == 5'h00 && slot_lamp == 5'h00))
    else $error("virtual assignment survived reset");

endmodule

// *** slot_rack_model.sv ***
// Purpose: stand-in for the relay modules seated in the five slots
// Assumes: module pins are static while powered
// Notes:   slot 1 measures, slot 2 switches only, slots 3-5 empty
`timescale 1ns/1ps
module slot_rack_model #(
  parameter logic [4:0] PRESENT = 5'h03,
  parameter logic [4:0] MEAS    = 5'h01
) (
  output logic [4:0] slot_present,
  output logic [4:0] slot_meas
);
  // ---------------------------------------------------------------------------
  // slot pins
  // ---------------------------------------------------------------------------
  // five slots; an empty slot can never claim measure channels
  assign slot_present = PRESENT;
  assign slot_meas    = MEAS & PRESENT;
endmodule

// *** system_channel_relay_selector_tb_top.sv ***
// Purpose: self-checking bench for the system channel relay selector
// Assumes: rack model fills slots 1 and 2 only
// Notes:   identity hold cut to 8 cycles to keep boot short
`timescale 1ns/1ps
module system_channel_relay_selector_tb_top;
  import relay_selector_pkg::*;
  localparam logic [31:0] BAD [7] = '{32'h1111, 32'h1123, 32'h1201, 32'h1301, 32'h1601, 32'h1100, 32'h11A1};
  logic         clock = 1'b0;
  logic         srst = 1'b1;
  logic [7:0]   awaddr = 8'h00;
  logic [7:0]   araddr = 8'h00;
  logic [31:0]  wdata = 32'h0;
  logic         awvalid = 1'b0;
  logic         wvalid = 1'b0;
  logic         bready = 1'b0;
  logic         arvalid = 1'b0;
  logic         rready = 1'b0;
  logic         awready, wready, bvalid, arready, rvalid, dvalid, ivalid, imeas, irq;
  logic [1:0]   bresp, rresp, rr;
  logic [31:0]  rdata, rd;
  logic [4:0]   present, meas, lamp;
  logic [124:0] relays, keep;
  logic [11:0]  dcode;
  logic [2:0]   islot;
  int           fails = 0;
  int           num_checks = 0;
  // half-period toggle gives 50 ns
  always #25 clock = ~clock;
  system_channel_relay_selector #(.ID_SHOW_CYCLES(8)) uut (.clock(clock), .srst(srst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .slot_present(present), .slot_meas(meas), .relay_drive(relays),
    .slot_lamp(lamp), .disp_chan_valid(dvalid), .disp_chan_code(dcode), .disp_ident_valid(ivalid),
    .disp_ident_slot(islot), .disp_ident_meas(imeas), .irq(irq));
  slot_rack_model rack (.slot_present(present), .slot_meas(meas));
  // ---------------------------------------------------------------------------
  // bus and check helpers
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    chk(bvalid, 1'b1);
    bready <= 1'b0;
    chk(bresp, RESP_OKAY);
  endtask
  task automatic rdreg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    chk(rvalid, 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // poll busy; a fixed wait would hide a slow boot
  task automatic idle;
    int n;
    n = 0;
    do begin
      rdreg(ADDR_SYS, rd, rr);
      n++;
    end while (rd[13] !== 1'b0 && n < 40);
    chk(rd[13], 1'b0);
  endtask
  task automatic cmd(input logic [31:0] c, input logic [1:0] st);
    wr(ADDR_STAT, 32'h3);
    wr(ADDR_CMD, c);
    #1;
    if (c[13:12] == 2'h1 && st == 2'h1) chk(relays, '0);
    idle;
    rdreg(ADDR_STAT, rd, rr);
    chk(rd[1:0], st);
  endtask
  function automatic logic [124:0] rl(input int s, input int c);
    rl = '0;
    rl[(s-1)*25+c-1] = 1'b1;
  endfunction
  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_boot;
    wait (ivalid === 1'b1);
    #1;
    chk({islot, imeas}, {3'h0, 1'b1});
    idle;
    chk({relays, lamp, dvalid}, '0);
    rdreg(ADDR_SLOTS, rd, rr);
    chk(rd, 32'h403);
    rdreg(8'h40, rd, rr);
    chk(rr, RESP_SLVERR);
    $display("boot done");
  endtask
  task automatic t_close;
    cmd(32'h1103, 2'h1);
    chk(relays, rl(1,3) | rl(1,25));
    chk({dvalid, dcode}, 13'h1103);
    wr(ADDR_CTRL, 32'h1);
    cmd(32'h1110, 2'h1);
    keep = rl(1,10) | rl(1,20) | rl(1,23) | rl(1,24) | rl(1,25);
    chk(relays, keep);
    chk(dcode, 12'h110);
    wr(ADDR_MASK, 32'h2);
    for (int i = 0; i < 7; i++) begin
      cmd(BAD[i], 2'h2);
      chk({relays, irq}, {keep, 1'b1});
    end
    wr(ADDR_STAT, 32'h2);
    chk(irq, 1'b0);
    wr(ADDR_MASK, 32'h0);
    $display("close done");
  endtask
  task automatic t_virt;
    wr(ADDR_CTRL, 32'h0);
    cmd(32'h7300, 2'h1);
    cmd(32'h7100, 2'h2);
    cmd(32'h7300, 2'h2);
    cmd(32'hF400, 2'h2);
    chk(lamp, 5'h04);
    cmd(32'h1305, 2'h1);
    chk(relays, rl(3,5) | rl(3,25));
    cmd(32'h0103, 2'h0);
    chk(relays, rl(3,5) | rl(3,25));
    cmd(32'h2000, 2'h1);
    chk({relays, dvalid}, '0);
    srst <= 1'b1;
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    // a close during boot must be refused
    wr(ADDR_CMD, 32'h1103);
    idle;
    rdreg(ADDR_STAT, rd, rr);
    chk({rd[1:0], relays, dvalid}, {2'h2, 125'h0, 1'b0});
    chk(lamp, 5'h00);
    $display("virtual done");
  endtask
  task automatic final_report;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // main sequence after eight reset cycles
  initial begin
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    t_boot;
    t_close;
    t_virt;
    final_report;
  end
  // watchdog sized well past the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    final_report;
  end
endmodule
